// ### rtl/idm_decode.sv
/*
  Data memory decoder for an 8-bit core: lower RAM, indirect-only upper
  RAM, special function space, expanded RAM and the multiplexed bus.
  Assumes the core holds a request until done pulses and keeps special
  function registers itself; this block only forwards those accesses.
*/
`timescale 1ns/1ps
module idm_decode #(
  parameter int XRAM_SIZE = idm_pkg::IDM_XRAM_SIZE_D,
  parameter int XRAM_AW = 13
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Internal access from core
  input wire logic int_req,
  input wire logic int_write,
  input wire idm_pkg::idm_mode_type int_mode,
  input wire logic [7:0] int_addr,
  input wire logic [7:0] int_wdata,
  // External move from core
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic ext_use_pointer,
  input wire logic [7:0] indirect_index,
  input wire logic [7:0] data_pointer_high,
  input wire logic [7:0] data_pointer_low,
  input wire logic [7:0] ext_wdata,
  input wire logic offchip_data_select,
  // Answers to core
  output logic done,
  output logic [7:0] rdata,
  output logic special_req,
  output logic special_write,
  output logic [7:0] special_addr,
  output logic [7:0] special_wdata,
  input wire logic [7:0] special_rdata,
  // Multiplexed bus pins
  output logic [7:0] port_zero_out,
  output logic port_zero_oe,
  input wire logic [7:0] port_zero_in,
  output logic [7:0] port_two_out,
  output logic port_two_drive,
  output logic addr_latch,
  output logic write_strobe_n,
  output logic read_strobe_n
);
  import idm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    idm_state_type state;
    logic [2:0] count;
    logic ext_cycle;
    logic wr;
    logic [7:0] rdata;
    logic done;
    logic sp_req;
    logic sp_wr;
    logic [7:0] sp_addr;
    logic [7:0] sp_wdata;
    logic [7:0] p0;
    logic p0_oe;
    logic [7:0] p2;
    logic p2_drv;
    logic ale;
    logic wr_n;
    logic rd_n;
    logic [1:0] src;
  } idm_state_reg_type;

  localparam logic [1:0] SRC_LOWER = 2'h0;
  localparam logic [1:0] SRC_UPPER = 2'h1;
  localparam logic [1:0] SRC_XRAM = 2'h2;
  localparam logic [1:0] SRC_NONE = 2'h3;

  idm_state_reg_type s_reg;
  idm_state_reg_type s_next;

  // Shared decode of internal accesses; direct beats address only above 7FH
  function automatic idm_target_type internal_target(input idm_mode_type mode, input logic [7:0] a);
    if (a <= IDM_LOWER_TOP) begin
      internal_target = IDM_TGT_LOWER;
    end else if (mode == IDM_MODE_DIRECT) begin
      internal_target = IDM_TGT_SPECIAL;
    end else begin
      internal_target = IDM_TGT_UPPER;
    end
  endfunction : internal_target

  // External target: on-chip only with select clear and address in range
  function automatic idm_target_type external_target(input logic sel, input logic [15:0] a);
    if (!sel && (32'(a) < XRAM_SIZE)) begin
      external_target = IDM_TGT_XRAM;
    end else begin
      external_target = IDM_TGT_BUS;
    end
  endfunction : external_target

  ////////////////////////////////////////////////////////////////////////
  // Address sources
  logic [15:0] ext_addr;
  idm_target_type int_tgt;
  idm_target_type ext_tgt;
  logic start_int;
  logic start_ext;
  logic [7:0] lower_rdata;
  logic [7:0] upper_rdata;
  logic [7:0] xram_rdata;

  // Index moves carry an 8-bit address, pointer moves 16 bits
  assign ext_addr = ext_use_pointer ? {data_pointer_high, data_pointer_low}
                                    : {IDM_BYTE_ZERO, indirect_index};
  assign int_tgt = internal_target(int_mode, int_addr);
  assign ext_tgt = external_target(offchip_data_select, ext_addr);
  // An access in flight to a RAM array also blocks a new start
  assign start_int = (s_reg.state == IDM_BUS_IDLE) && int_req && !s_reg.done && (s_reg.src == SRC_NONE);
  assign start_ext = (s_reg.state == IDM_BUS_IDLE) && ext_req && !int_req && !s_reg.done
                     && (s_reg.src == SRC_NONE);

  ////////////////////////////////////////////////////////////////////////
  // Separate arrays: upper RAM never aliases the special space
  idm_ram #(.DEPTH(128), .AW(7)) u_lower (
    .clock(clock),
    .enable(start_int && int_tgt == IDM_TGT_LOWER),
    .write(int_write),
    .address(int_addr[6:0]),
    .write_data(int_wdata),
    .read_data(lower_rdata)
  );

  idm_ram #(.DEPTH(128), .AW(7)) u_upper (
    .clock(clock),
    .enable(start_int && int_tgt == IDM_TGT_UPPER),
    .write(int_write),
    .address(int_addr[6:0]),
    .write_data(int_wdata),
    .read_data(upper_rdata)
  );

  // Expanded RAM; a third module would duplicate this, so reuse it
  idm_ram #(.DEPTH(XRAM_SIZE), .AW(XRAM_AW)) u_xram (
    .clock(clock),
    .enable(start_ext && ext_tgt == IDM_TGT_XRAM),
    .write(ext_write),
    .address(ext_addr[XRAM_AW-1:0]),
    .write_data(ext_wdata),
    .read_data(xram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.sp_req = 1'b0;
    s_next.ale = 1'b0;
    // Registered RAM data lands one cycle after the request
    case (s_reg.src)
      SRC_LOWER: s_next.rdata = lower_rdata;
      SRC_UPPER: s_next.rdata = upper_rdata;
      SRC_XRAM: s_next.rdata = xram_rdata;
      default: s_next.rdata = s_reg.rdata;
    endcase
    if (s_reg.src != SRC_NONE) begin
      s_next.done = 1'b1;
      s_next.src = SRC_NONE;
    end
    case (s_reg.state)
      IDM_BUS_IDLE: begin
        if (start_int) begin
          case (int_tgt)
            IDM_TGT_LOWER: s_next.src = SRC_LOWER;
            IDM_TGT_UPPER: s_next.src = SRC_UPPER;
            default: begin
              s_next.sp_req = 1'b1;
              s_next.sp_wr = int_write;
              s_next.sp_addr = int_addr;
              s_next.sp_wdata = int_wdata;
              s_next.state = IDM_XRAM_WAIT;
            end
          endcase
        end else if (start_ext) begin
          s_next.wr = ext_write;
          if (ext_tgt == IDM_TGT_XRAM) begin
            s_next.src = SRC_XRAM;
          end else begin
            s_next.state = IDM_BUS_ADDR;
            s_next.count = 3'(IDM_ADDR_CYCLES - 1);
            s_next.p0 = ext_addr[7:0];
            s_next.p0_oe = 1'b1;
            s_next.p2 = ext_use_pointer ? ext_addr[15:8] : s_reg.p2;
            s_next.p2_drv = 1'b1;
            s_next.ale = 1'b1;
            s_next.ext_cycle = 1'b1;
          end
        end
      end
      IDM_BUS_ADDR: begin
        s_next.ale = s_reg.count != 3'h0;
        if (s_reg.count == 3'h0) begin
          s_next.state = IDM_BUS_STROBE;
          s_next.count = 3'(IDM_STROBE_CYCLES - 1);
          s_next.p0 = ext_wdata;
          s_next.p0_oe = s_reg.wr;
          s_next.wr_n = !s_reg.wr;
          s_next.rd_n = s_reg.wr;
        end else begin
          s_next.count = s_reg.count - 3'h1;
        end
      end
      IDM_BUS_STROBE: begin
        if (s_reg.count == 3'h0) begin
          s_next.state = IDM_BUS_DONE;
          s_next.rdata = s_reg.wr ? s_reg.rdata : port_zero_in;
          s_next.wr_n = 1'b1;
          s_next.rd_n = 1'b1;
        end else begin
          s_next.count = s_reg.count - 3'h1;
        end
      end
      IDM_BUS_DONE: begin
        s_next.p0_oe = 1'b0;
        s_next.ext_cycle = 1'b0;
        s_next.done = 1'b1;
        s_next.state = IDM_BUS_IDLE;
      end
      IDM_XRAM_WAIT: begin
        // Special space answers combinationally in the cycle after request
        s_next.rdata = special_rdata;
        s_next.done = 1'b1;
        s_next.state = IDM_BUS_IDLE;
      end
      default: s_next.state = IDM_BUS_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{state: IDM_BUS_IDLE, count: 3'h0, ext_cycle: 1'b0, wr: 1'b0,
                 rdata: IDM_BYTE_ZERO, done: 1'b0, sp_req: 1'b0, sp_wr: 1'b0,
                 sp_addr: IDM_BYTE_ZERO, sp_wdata: IDM_BYTE_ZERO,
                 p0: IDM_BYTE_ONES, p0_oe: 1'b0, p2: IDM_BYTE_ONES,
                 p2_drv: 1'b0, ale: 1'b0, wr_n: 1'b1, rd_n: 1'b1,
                 src: SRC_NONE};
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs straight from the state register
  assign done = s_reg.done;
  assign rdata = s_reg.rdata;
  assign special_req = s_reg.sp_req;
  assign special_write = s_reg.sp_wr;
  assign special_addr = s_reg.sp_addr;
  assign special_wdata = s_reg.sp_wdata;
  assign port_zero_out = s_reg.p0;
  assign port_zero_oe = s_reg.p0_oe;
  assign port_two_out = s_reg.p2;
  assign port_two_drive = s_reg.p2_drv;
  assign addr_latch = s_reg.ale;
  assign write_strobe_n = s_reg.wr_n;
  assign read_strobe_n = s_reg.rd_n;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  a_xram_quiet: assert property (@(posedge clock) disable iff (!reset_n)
    start_ext && ext_tgt == IDM_TGT_XRAM |=> write_strobe_n && read_strobe_n && !addr_latch
    ##1 write_strobe_n && read_strobe_n) else $error("bus activity on expanded RAM access");
  a_select_offchip: assert property (@(posedge clock) disable iff (!reset_n)
    start_ext && offchip_data_select |=> addr_latch) else $error("select set not sent to bus");
  a_direct_special: assert property (@(posedge clock) disable iff (!reset_n)
    start_int && int_mode == IDM_MODE_DIRECT && int_addr > IDM_LOWER_TOP |=> special_req)
    else $error("direct high access missed special space");
  a_indirect_upper: assert property (@(posedge clock) disable iff (!reset_n)
    start_int && int_mode != IDM_MODE_DIRECT && int_addr > IDM_LOWER_TOP |=> !special_req ##1 done)
    else $error("indirect high access left upper RAM");
  a_lower_both: assert property (@(posedge clock) disable iff (!reset_n)
    start_int && int_addr <= IDM_LOWER_TOP |=> !special_req ##1 done)
    else $error("lower RAM access mishandled");
  a_pointer_high: assert property (@(posedge clock) disable iff (!reset_n)
    start_ext && ext_use_pointer && ext_tgt == IDM_TGT_BUS |=>
    port_two_out == $past(data_pointer_high) && port_zero_out == $past(data_pointer_low))
    else $error("pointer address not on ports");
  a_index_low: assert property (@(posedge clock) disable iff (!reset_n)
    start_ext && !ext_use_pointer && ext_tgt == IDM_TGT_BUS |=> port_zero_out == $past(indirect_index)
    && port_two_out == $past(port_two_out)) else $error("index address wrong");
  // Latch enable stands for the two address cycles, then drops
  sequence s_addr_phase;
    addr_latch [*2] ##1 !addr_latch;
  endsequence
  a_strobe_dir: assert property (@(posedge clock) disable iff (!reset_n)
    start_ext && ext_tgt == IDM_TGT_BUS |=> s_addr_phase ##1 (write_strobe_n != read_strobe_n)
    && port_two_drive) else $error("strobe missing after address");
endmodule : idm_decode

// ### rtl/idm_pkg.sv
/*
  Constants, sizes and types for the internal data memory decoder.
  Assumes a single core clock domain; no software-visible registers.
*/
package idm_pkg;
  // Internal data space boundaries
  localparam logic [7:0] IDM_LOWER_TOP = 8'h7F;
  localparam logic [7:0] IDM_UPPER_BASE = 8'h80;
  // Expanded RAM sizes by variant
  localparam int IDM_XRAM_SIZE_A = 256;
  localparam int IDM_XRAM_SIZE_B = 768;
  localparam int IDM_XRAM_SIZE_C = 1792;
  localparam int IDM_XRAM_SIZE_D = 7936;
  localparam int IDM_XRAM_MAX_ADDR = 16'h1FFF;
  // Bus cycle phase lengths in core clocks
  localparam int IDM_ADDR_CYCLES = 2;
  localparam int IDM_STROBE_CYCLES = 3;
  localparam logic [7:0] IDM_BYTE_ZERO = 8'h00;
  localparam logic [7:0] IDM_BYTE_ONES = 8'hFF;

  // Addressing modes of an internal access
  typedef enum logic [1:0] {
    IDM_MODE_DIRECT,
    IDM_MODE_INDIRECT,
    IDM_MODE_STACK
  } idm_mode_type;

  // Target of a decoded access
  typedef enum logic [2:0] {
    IDM_TGT_LOWER,
    IDM_TGT_UPPER,
    IDM_TGT_SPECIAL,
    IDM_TGT_XRAM,
    IDM_TGT_BUS
  } idm_target_type;

  // Decoder states: external bus cycle phases plus the special space wait
  typedef enum logic [2:0] {
    IDM_BUS_IDLE,
    IDM_BUS_ADDR,
    IDM_BUS_STROBE,
    IDM_BUS_DONE,
    IDM_XRAM_WAIT
  } idm_state_type;
endpackage : idm_pkg

// ### rtl/idm_ram.sv
/*
  Single-port synchronous byte memory with registered read data.
  Assumes one access per cycle from the decoder above it.
*/
`timescale 1ns/1ps
module idm_ram #(
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  // Clock
  input wire logic clock,
  // Access port
  input wire logic enable,
  input wire logic write,
  input wire logic [AW-1:0] address,
  input wire logic [7:0] write_data,
  output logic [7:0] read_data
);
  logic [7:0] mem_reg [DEPTH];

  // Storage has no reset; read data is registered
  always_ff @(posedge clock) begin
    if (enable && write) begin
      mem_reg[address] <= write_data;
    end
    if (enable) begin
      read_data <= mem_reg[address];
    end
  end
endmodule : idm_ram

// ### verif/idm_xmem.sv
/*
  Behavioural external data memory on the multiplexed port bus.
  Assumes the decoder drives address low byte on port zero while the
  latch enable is high, and active-low read and write strobes.
*/
`timescale 1ns/1ps
module idm_xmem #(
  parameter int READ_DELAY = 0
) (
  // Clock
  input wire logic clock,
  // Bus pins as seen by the memory
  input wire logic addr_latch,
  input wire logic [7:0] port_zero_out,
  input wire logic port_zero_oe,
  input wire logic [7:0] port_two_out,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  // Resolved port zero level
  output logic [7:0] port_zero_in
);
  logic [7:0] mem [0:65535];
  logic [15:0] latched_addr = 16'h0000;
  logic [7:0] last_level = 8'h00;
  int read_age = 0;

  ////////////////////////////////////////////////////////////
  // Latch address, store on write strobe, age the read strobe
  always @(posedge clock) begin
    if (addr_latch && port_zero_oe) begin
      latched_addr <= {port_two_out, port_zero_out};
    end
    if (!write_strobe_n && port_zero_oe) begin
      mem[latched_addr] <= port_zero_out;
    end
    read_age <= read_strobe_n ? 0 : read_age + 1;
    last_level <= port_zero_in;
  end

  // Released wire shows inverted last level so stale data never passes
  always_comb begin
    if (port_zero_oe) begin
      port_zero_in = port_zero_out;
    end else if (!read_strobe_n && read_age >= READ_DELAY) begin
      port_zero_in = mem[latched_addr];
    end else begin
      port_zero_in = ~last_level;
    end
  end
endmodule : idm_xmem

// ### verif/testbench.sv
/*
  Self-checking bench for the data memory decoder: table of accesses,
  then reset checks. Assumes the decoder's answer latencies of 2 and 7.
*/
`timescale 1ns/1ps
module testbench;
  import idm_pkg::*;
  typedef struct {
    logic ext;
    logic wr;
    idm_mode_type mode;
    logic ptr;
    logic sel;
    logic [15:0] addr;
    logic [7:0] data;
    logic [7:0] exp_rd;
    int lat;
    logic spec;
    logic bus;
  } idm_row_type;
  logic clock, reset_n, int_req, int_write, ext_req, ext_write, ext_use_pointer, offchip_data_select;
  idm_mode_type int_mode;
  logic [7:0] int_addr, int_wdata, indirect_index, data_pointer_high, data_pointer_low, ext_wdata;
  logic done, special_req, special_write, port_zero_oe, port_two_drive, addr_latch;
  logic write_strobe_n, read_strobe_n;
  logic [7:0] rdata, special_addr, special_wdata, special_rdata, port_zero_out, port_zero_in, port_two_out;
  logic [7:0] rd_value;
  int miscompares = 0;
  int tests_run = 0;
  idm_row_type rows [21] = '{
    '{0, 1, IDM_MODE_DIRECT, 0, 0, 16'h0010, 8'hA5, 8'h00, 2, 0, 0},
    '{0, 0, IDM_MODE_INDIRECT, 0, 0, 16'h0010, 8'h00, 8'hA5, 2, 0, 0},
    '{0, 1, IDM_MODE_INDIRECT, 0, 0, 16'h0090, 8'h3C, 8'h00, 2, 0, 0},
    '{0, 0, IDM_MODE_DIRECT, 0, 0, 16'h0090, 8'h00, 8'hCA, 2, 1, 0},
    '{0, 1, IDM_MODE_DIRECT, 0, 0, 16'h0090, 8'h11, 8'h00, 2, 1, 0},
    '{0, 0, IDM_MODE_INDIRECT, 0, 0, 16'h0090, 8'h00, 8'h3C, 2, 0, 0},
    '{0, 1, IDM_MODE_STACK, 0, 0, 16'h00FF, 8'h77, 8'h00, 2, 0, 0},
    '{0, 0, IDM_MODE_INDIRECT, 0, 0, 16'h00FF, 8'h00, 8'h77, 2, 0, 0},
    '{1, 1, IDM_MODE_DIRECT, 0, 0, 16'h00A0, 8'h5E, 8'h00, 2, 0, 0},
    '{1, 0, IDM_MODE_DIRECT, 1, 0, 16'h00A0, 8'h00, 8'h5E, 2, 0, 0},
    '{1, 1, IDM_MODE_DIRECT, 1, 0, 16'h1EFF, 8'h21, 8'h00, 2, 0, 0},
    '{1, 0, IDM_MODE_DIRECT, 1, 0, 16'h1EFF, 8'h00, 8'h21, 2, 0, 0},
    '{1, 1, IDM_MODE_DIRECT, 1, 0, 16'h2000, 8'h42, 8'h00, 7, 0, 1},
    '{1, 0, IDM_MODE_DIRECT, 1, 0, 16'h2000, 8'h00, 8'h42, 7, 0, 1},
    '{1, 1, IDM_MODE_DIRECT, 1, 1, 16'h00A0, 8'h99, 8'h00, 7, 0, 1},
    '{1, 0, IDM_MODE_DIRECT, 0, 0, 16'h00A0, 8'h00, 8'h5E, 2, 0, 0},
    '{1, 0, IDM_MODE_DIRECT, 1, 1, 16'h00A0, 8'h00, 8'h99, 7, 0, 1},
    '{1, 1, IDM_MODE_DIRECT, 0, 1, 16'h0033, 8'h12, 8'h00, 7, 0, 1},
    '{1, 0, IDM_MODE_DIRECT, 0, 1, 16'h0033, 8'h00, 8'h12, 7, 0, 1},
    '{1, 1, IDM_MODE_DIRECT, 1, 0, 16'h1F00, 8'h6B, 8'h00, 7, 0, 1},
    '{1, 0, IDM_MODE_DIRECT, 1, 0, 16'h1F00, 8'h00, 8'h6B, 7, 0, 1}
  };

  ////////////////////////////////////////////////////////////
  // Core clock, 20 ns period
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // Stand-in for the special function block outside the decoder
  assign special_rdata = special_addr ^ 8'h5A;

  idm_decode dut (.clock(clock), .reset_n(reset_n), .int_req(int_req), .int_write(int_write),
    .int_mode(int_mode), .int_addr(int_addr), .int_wdata(int_wdata), .ext_req(ext_req),
    .ext_write(ext_write), .ext_use_pointer(ext_use_pointer), .indirect_index(indirect_index),
    .data_pointer_high(data_pointer_high), .data_pointer_low(data_pointer_low), .ext_wdata(ext_wdata),
    .offchip_data_select(offchip_data_select), .done(done), .rdata(rdata), .special_req(special_req),
    .special_write(special_write), .special_addr(special_addr), .special_wdata(special_wdata),
    .special_rdata(special_rdata), .port_zero_out(port_zero_out), .port_zero_oe(port_zero_oe),
    .port_zero_in(port_zero_in), .port_two_out(port_two_out), .port_two_drive(port_two_drive),
    .addr_latch(addr_latch), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n));

  // Slow partner: read data appears one cycle into the strobe
  idm_xmem #(.READ_DELAY(1)) xmem (.clock(clock), .addr_latch(addr_latch), .port_zero_out(port_zero_out),
    .port_zero_oe(port_zero_oe), .port_two_out(port_two_out), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .port_zero_in(port_zero_in));

  ////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] expected, input string what);
    tests_run++;
    if (seen !== expected) begin
      miscompares++;
      $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, expected);
    end
  endtask : check

  // One access, held until done; watches pins cycle by cycle
  task access(input idm_row_type r);
    int n;
    logic bus_seen, wr_seen, rd_seen, spec_seen;
    logic [7:0] p2_before;
    @(posedge clock);
    #1;
    p2_before = port_two_out;
    n = 0;
    bus_seen = 1'b0;
    wr_seen = 1'b0;
    rd_seen = 1'b0;
    spec_seen = 1'b0;
    if (r.ext) begin
      {ext_write, ext_use_pointer, offchip_data_select, ext_wdata} = {r.wr, r.ptr, r.sel, r.data};
      {indirect_index, data_pointer_low} = {r.addr[7:0], r.addr[7:0]};
      data_pointer_high = r.ptr ? r.addr[15:8] : ~r.addr[15:8];
      ext_req = 1'b1;
    end else begin
      {int_write, int_addr, int_wdata} = {r.wr, r.addr[7:0], r.data};
      int_mode = r.mode;
      int_req = 1'b1;
    end
    while (n < 20 && done !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
      bus_seen |= (addr_latch === 1'b1) || (port_zero_oe === 1'b1);
      wr_seen |= (write_strobe_n === 1'b0);
      rd_seen |= (read_strobe_n === 1'b0);
      if (n == 1 && addr_latch === 1'b1) begin
        check(port_zero_out, r.addr[7:0], "address low byte");
        check(port_two_out, r.ptr ? r.addr[15:8] : p2_before, "address high byte");
        check(port_two_drive, 1'b1, "port two output");
      end
      if (special_req === 1'b1) begin
        spec_seen = 1'b1;
        check(special_addr, r.addr[7:0], "special address");
        check(special_write, r.wr, "special direction");
        check(special_wdata, r.data, "special write data");
      end
    end
    int_req = 1'b0;
    ext_req = 1'b0;
    rd_value = rdata;
    check(8'(n), 8'(r.lat), "latency");
    check(bus_seen, r.bus, "bus activity");
    check(wr_seen, r.bus & r.wr, "write strobe");
    check(rd_seen, r.bus & ~r.wr, "read strobe");
    check(spec_seen, r.spec, "special forward");
    if (!r.wr) begin
      check(rd_value, r.exp_rd, "read data");
    end
  endtask : access

  task check_reset_state;
    check({done, write_strobe_n, read_strobe_n, port_zero_oe, port_two_drive, addr_latch}, 8'h18, "reset pins");
    check(port_zero_out, 8'hFF, "reset port zero");
    check(port_two_out, 8'hFF, "reset port two");
  endtask : check_reset_state

  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////
  // Table first, then reset in mid bus cycle and recovery
  initial begin
    {reset_n, int_req, int_write, ext_req, ext_write, ext_use_pointer, offchip_data_select} = 7'h00;
    int_mode = IDM_MODE_DIRECT;
    {int_addr, int_wdata, indirect_index, data_pointer_high, data_pointer_low, ext_wdata} = 48'h0;
    repeat (3) @(posedge clock);
    #1;
    check_reset_state();
    reset_n = 1'b1;
    foreach (rows[i]) begin
      access(rows[i]);
    end
    @(posedge clock);
    #1;
    {ext_write, ext_use_pointer, offchip_data_select, data_pointer_high, data_pointer_low} = {3'b111, 16'h3000};
    ext_req = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    reset_n = 1'b0;
    ext_req = 1'b0;
    #1;
    check_reset_state();
    @(posedge clock);
    #1;
    reset_n = 1'b1;
    access(rows[13]);
    print_verdict();
  end

  // Hang guard, far beyond the hundred or so cycles the table needs
  initial begin
    #200000;
    miscompares++;
    print_verdict();
  end
endmodule : testbench
